// File: pll_setup_sequencer.sv
// Behaviour
// - Use PLL bypass when dividing the input alone reaches the target.
// - Apply found dividers, then switch main clock to PLL output if needed.
// - Status codes: 0 ok, 1 bad frequency, 2 bad mode, 3 none, 4 unlocked.
// - Return resulting system frequency in kHz with the status.
// - Mode 0 exact, 1 at most, 2 at least, 3 closest.
// - Only consider settings keeping PLL output at or below 50 MHz.
// - Reject input frequency outside 10000..25000 kHz, echo input, keep settings.
// - Reject target outside 1..50000 kHz, echo input, keep settings.
// - Exact mode needs precise match; exact match is preferred in all modes.
// - At-most mode never exceeds the requested frequency.
// - At-least mode never falls below the requested frequency.
// - Closest mode picks the nearest frequency above or below.
// - Undefined mode returns bad-mode, echoes input, keeps settings.
// - No fitting setting returns no-solution, echoes input, keeps settings.
// - Zero poll limit waits for lock without end.
// - Nonzero limit checks lock that many times, then times out unchanged.
// - System divider above 255 needed means bad frequency.
module pll_setup_sequencer import pll_setup_pkg::*; (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire request_s req,
    input wire logic pll_lock_pin,
    output logic busy,
    output logic result_valid,
    output result_s result,
    output pll_control_s pll_control_setting,
    output logic [7:0] system_clock_divider,
    output logic main_clock_from_pll,
    output logic pll_bypass
);

    seq_state_e state;
    request_s req_q;
    logic [FREQ_W-1:0] fin;
    logic [FREQ_W-1:0] target;
    logic [5:0] m;
    logic [16:0] fout;
    logic [16:0] next_fout;
    logic [FREQ_W-1:0] q_reg;
    logic div_start;
    logic [FREQ_W-1:0] div_a;
    logic [FREQ_W-1:0] div_b;
    logic [FREQ_W-1:0] div_quo;
    logic [FREQ_W-1:0] div_rem;
    logic div_done;
    logic lock_seen;
    logic ex_found, le_found, ge_found;
    logic [5:0] ex_m, le_m, ge_m;
    logic [7:0] ex_d, le_d, ge_d;
    logic [FREQ_W-1:0] le_freq, ge_freq;
    logic [5:0] pick_m;
    logic [7:0] pick_d;
    logic [FREQ_W-1:0] pick_freq;
    logic [CMD_W-1:0] polls;
    logic [1:0] settle;
    pll_control_s saved_pll;

    assign next_fout = fout + {1'b0, fin};

    lock_sync u_lock_sync (
        .core_clk(core_clk),
        .rst(rst),
        .async_in(pll_lock_pin),
        .sync_out(lock_seen)
    );

    freq_divider u_freq_divider (
        .core_clk(core_clk),
        .rst(rst),
        .start(div_start),
        .dividend(div_a),
        .divisor(div_b),
        .quotient(div_quo),
        .remainder(div_rem),
        .done(div_done)
    );

    always_ff @(posedge core_clk) begin
        if (rst) begin
            req_q <= '0;
            fin <= '0;
            target <= '0;
        end else if (state == st_idle && req_valid) begin
            req_q <= req;
            fin <= req.in_freq_khz[FREQ_W-1:0];
            target <= req.target_khz[FREQ_W-1:0];
        end
    end

    // Candidate bookkeeping: first hit kept, so bypass wins ties.
    always_ff @(posedge core_clk) begin
        if (rst || state == st_check) begin
            ex_found <= 1'b0;
            le_found <= 1'b0;
            ge_found <= 1'b0;
            ex_m <= '0;
            le_m <= '0;
            ge_m <= '0;
            ex_d <= '0;
            le_d <= '0;
            ge_d <= '0;
            le_freq <= '0;
            ge_freq <= '0;
        end else if (div_done) begin
            if (state == st_quot && div_rem == '0 && div_quo != '0
                && div_quo <= SYSDIV_MAX && !ex_found) begin
                ex_found <= 1'b1;
                ex_m <= m;
                ex_d <= div_quo[7:0];
            end
            if (state == st_ge && (!ge_found || div_quo < ge_freq)) begin
                ge_found <= 1'b1;
                ge_m <= m;
                ge_d <= q_reg[7:0];
                ge_freq <= div_quo;
            end
            if (state == st_le && (!le_found || div_quo > le_freq)) begin
                le_found <= 1'b1;
                le_m <= m;
                le_d <= 8'(q_reg + 16'h0001);
                le_freq <= div_quo;
            end
        end
    end

    always_comb begin
        pick_m = ex_m;
        pick_d = ex_d;
        pick_freq = target;
        if (!ex_found) begin
            if (req_q.mode == match_at_least || (req_q.mode == match_closest && ge_found
                && (!le_found || (ge_freq - target) < (target - le_freq)))) begin
                pick_m = ge_m;
                pick_d = ge_d;
                pick_freq = ge_freq;
            end else begin
                pick_m = le_m;
                pick_d = le_d;
                pick_freq = le_freq;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= st_idle;
            busy <= 1'b0;
            result_valid <= 1'b0;
            result <= '{code: result_ok, sys_freq_khz: '0};
            m <= '0;
            fout <= '0;
            q_reg <= '0;
            div_start <= 1'b0;
            div_a <= '0;
            div_b <= '0;
            polls <= '0;
            settle <= '0;
            saved_pll <= '0;
            pll_control_setting <= '0;
            system_clock_divider <= SYSDIV_RESET;
            main_clock_from_pll <= 1'b0;
            pll_bypass <= 1'b0;
        end else begin
            div_start <= 1'b0;
            result_valid <= 1'b0;
            case (state)
                st_idle: begin
                    if (req_valid) begin
                        busy <= 1'b1;
                        state <= st_check;
                    end
                end
                st_check: begin
                    result.sys_freq_khz <= req_q.in_freq_khz;
                    if (req_q.in_freq_khz < IN_FREQ_MIN_KHZ
                        || req_q.in_freq_khz > IN_FREQ_MAX_KHZ
                        || req_q.target_khz < TARGET_MIN_KHZ
                        || req_q.target_khz > TARGET_MAX_KHZ) begin
                        result.code <= result_bad_frequency;
                        result_valid <= 1'b1;
                        busy <= 1'b0;
                        state <= st_idle;
                    end else if (req_q.mode > match_closest) begin
                        result.code <= result_bad_mode;
                        result_valid <= 1'b1;
                        busy <= 1'b0;
                        state <= st_idle;
                    end else begin
                        m <= FEEDBACK_BYPASS;
                        fout <= {1'b0, fin};
                        div_a <= fin;
                        div_b <= target;
                        div_start <= 1'b1;
                        state <= st_quot;
                    end
                end
                st_quot: begin
                    if (div_done) begin
                        q_reg <= div_quo;
                        if (m == FEEDBACK_BYPASS && div_quo > SYSDIV_MAX) begin
                            result.code <= result_bad_frequency;
                            result_valid <= 1'b1;
                            busy <= 1'b0;
                            state <= st_idle;
                        end else if (div_rem == '0 && div_quo != '0) begin
                            state <= st_next;
                        end else if (div_quo != '0 && div_quo <= SYSDIV_MAX) begin
                            div_a <= fout[FREQ_W-1:0];
                            div_b <= div_quo;
                            div_start <= 1'b1;
                            state <= st_ge;
                        end else if (div_quo < SYSDIV_MAX) begin
                            div_a <= fout[FREQ_W-1:0];
                            div_b <= div_quo + 16'h0001;
                            div_start <= 1'b1;
                            state <= st_le;
                        end else begin
                            state <= st_next;
                        end
                    end
                end
                st_ge: begin
                    if (div_done) begin
                        if (q_reg < SYSDIV_MAX) begin
                            div_a <= fout[FREQ_W-1:0];
                            div_b <= q_reg + 16'h0001;
                            div_start <= 1'b1;
                            state <= st_le;
                        end else begin
                            state <= st_next;
                        end
                    end
                end
                st_le: begin
                    if (div_done) begin
                        state <= st_next;
                    end
                end
                st_next: begin
                    if (m == FEEDBACK_MAX || next_fout > PLL_OUT_MAX_KHZ) begin
                        state <= st_decide;
                    end else begin
                        m <= m + 6'h01;
                        fout <= next_fout;
                        div_a <= next_fout[FREQ_W-1:0];
                        div_b <= target;
                        div_start <= 1'b1;
                        state <= st_quot;
                    end
                end
                st_decide: begin
                    if (!ex_found && (req_q.mode == match_exact
                        || (req_q.mode == match_at_most && !le_found)
                        || (req_q.mode == match_at_least && !ge_found)
                        || (req_q.mode == match_closest && !le_found && !ge_found))) begin
                        result.code <= result_no_solution;
                        result_valid <= 1'b1;
                        busy <= 1'b0;
                        state <= st_idle;
                    end else if (pick_m == FEEDBACK_BYPASS) begin
                        pll_bypass <= 1'b1;
                        main_clock_from_pll <= 1'b0;
                        system_clock_divider <= pick_d;
                        result.code <= result_ok;
                        result.sys_freq_khz <= {16'h0000, pick_freq};
                        result_valid <= 1'b1;
                        busy <= 1'b0;
                        state <= st_idle;
                    end else begin
                        saved_pll <= pll_control_setting;
                        pll_control_setting <= '{post_code: POST_DIV_CODE,
                                                 feedback_m1: 5'(pick_m - 6'h01)};
                        polls <= '0;
                        settle <= LOCK_SETTLE;
                        state <= st_lock;
                    end
                end
                st_lock: begin
                    // A lock level from before the new setting is stale until it clears the synchroniser.
                    if (settle != '0) begin
                        settle <= settle - 2'h1;
                    end else if (lock_seen) begin
                        pll_bypass <= 1'b0;
                        system_clock_divider <= pick_d;
                        main_clock_from_pll <= 1'b1;
                        result.code <= result_ok;
                        result.sys_freq_khz <= {16'h0000, pick_freq};
                        result_valid <= 1'b1;
                        busy <= 1'b0;
                        state <= st_idle;
                    end else if (req_q.lock_poll_limit != '0
                                 && polls + 32'h1 >= req_q.lock_poll_limit) begin
                        pll_control_setting <= saved_pll;
                        result.code <= result_lock_timeout;
                        result_valid <= 1'b1;
                        busy <= 1'b0;
                        state <= st_idle;
                    end else begin
                        polls <= polls + 32'h1;
                    end
                end
                default: begin
                    state <= st_idle;
                end
            endcase
        end
    end

    sequence s_accept;
        state == st_idle && req_valid;
    endsequence

    sequence s_fail_done;
        result_valid && result.code != result_ok;
    endsequence

    property p_busy_after_accept;
        @(posedge core_clk) disable iff (rst)
        s_accept |=> busy ##0 !result_valid;
    endproperty
    a_busy_after_accept: assert property (p_busy_after_accept)
        else $error("busy not raised after request accepted");

    property p_done_drops_busy;
        @(posedge core_clk) disable iff (rst)
        result_valid |-> !busy && $past(busy);
    endproperty
    a_done_drops_busy: assert property (p_done_drops_busy)
        else $error("result given without busy falling");

    property p_code_range;
        @(posedge core_clk) disable iff (rst)
        result_valid |-> result.code <= result_lock_timeout;
    endproperty
    a_code_range: assert property (p_code_range)
        else $error("status code out of range");

    property p_fail_echo;
        @(posedge core_clk) disable iff (rst)
        s_fail_done |-> result.sys_freq_khz == req_q.in_freq_khz;
    endproperty
    a_fail_echo: assert property (p_fail_echo)
        else $error("failure did not echo input frequency");

    property p_fail_keeps_divider;
        @(posedge core_clk) disable iff (rst)
        s_fail_done |-> $stable(system_clock_divider) && $stable(main_clock_from_pll);
    endproperty
    a_fail_keeps_divider: assert property (p_fail_keeps_divider)
        else $error("failed request changed clock settings");

    property p_exact_mode;
        @(posedge core_clk) disable iff (rst)
        result_valid && result.code == result_ok && req_q.mode == match_exact
            |-> result.sys_freq_khz == req_q.target_khz;
    endproperty
    a_exact_mode: assert property (p_exact_mode)
        else $error("exact mode returned another frequency");

    property p_at_most;
        @(posedge core_clk) disable iff (rst)
        result_valid && result.code == result_ok && req_q.mode == match_at_most
            |-> result.sys_freq_khz <= req_q.target_khz;
    endproperty
    a_at_most: assert property (p_at_most)
        else $error("at-most mode exceeded target");

    property p_at_least;
        @(posedge core_clk) disable iff (rst)
        result_valid && result.code == result_ok && req_q.mode == match_at_least
            |-> result.sys_freq_khz >= req_q.target_khz;
    endproperty
    a_at_least: assert property (p_at_least)
        else $error("at-least mode fell below target");

    property p_pll_out_limit;
        @(posedge core_clk) disable iff (rst)
        state == st_quot |-> fout <= PLL_OUT_MAX_KHZ;
    endproperty
    a_pll_out_limit: assert property (p_pll_out_limit)
        else $error("PLL output above limit considered");

    property p_lock_switch;
        @(posedge core_clk) disable iff (rst)
        state == st_lock && settle == '0 && lock_seen |=> result_valid && main_clock_from_pll
            && result.code == result_ok;
    endproperty
    a_lock_switch: assert property (p_lock_switch)
        else $error("lock did not switch main clock to PLL");

    property p_poll_bound;
        @(posedge core_clk) disable iff (rst)
        state == st_lock && req_q.lock_poll_limit != '0 |-> polls < req_q.lock_poll_limit;
    endproperty
    a_poll_bound: assert property (p_poll_bound)
        else $error("lock checked more often than the limit");

    property p_no_limit_waits;
        @(posedge core_clk) disable iff (rst)
        state == st_lock && req_q.lock_poll_limit == '0 && !lock_seen |=> state == st_lock;
    endproperty
    a_no_limit_waits: assert property (p_no_limit_waits)
        else $error("zero limit gave up waiting for lock");

endmodule : pll_setup_sequencer

// File: pll_setup_pkg.sv
package pll_setup_pkg;

    localparam int FREQ_W = 16;
    localparam int CMD_W = 32;

    localparam logic [CMD_W-1:0] IN_FREQ_MIN_KHZ = 32'h0000_2710;
    localparam logic [CMD_W-1:0] IN_FREQ_MAX_KHZ = 32'h0000_61a8;
    localparam logic [CMD_W-1:0] TARGET_MIN_KHZ = 32'h0000_0001;
    localparam logic [CMD_W-1:0] TARGET_MAX_KHZ = 32'h0000_c350;
    localparam logic [16:0] PLL_OUT_MAX_KHZ = 17'h0c350;
    localparam logic [FREQ_W-1:0] SYSDIV_MAX = 16'h00ff;
    localparam logic [5:0] FEEDBACK_MAX = 6'h20;
    localparam logic [5:0] FEEDBACK_BYPASS = 6'h01;
    localparam logic [1:0] POST_DIV_CODE = 2'h1;
    localparam logic [4:0] DIV_STEPS = 5'h10;
    localparam logic [1:0] LOCK_SETTLE = 2'h2;
    localparam logic [7:0] SYSDIV_RESET = 8'h01;

    typedef enum logic [CMD_W-1:0] {
        match_exact = 32'h0000_0000,
        match_at_most = 32'h0000_0001,
        match_at_least = 32'h0000_0002,
        match_closest = 32'h0000_0003
    } match_mode_e;

    typedef enum logic [2:0] {
        result_ok = 3'h0,
        result_bad_frequency = 3'h1,
        result_bad_mode = 3'h2,
        result_no_solution = 3'h3,
        result_lock_timeout = 3'h4
    } result_code_e;

    typedef enum logic [3:0] {
        st_idle = 4'b0000,
        st_check = 4'b0001,
        st_quot = 4'b0010,
        st_ge = 4'b0011,
        st_le = 4'b0100,
        st_next = 4'b0101,
        st_decide = 4'b0110,
        st_lock = 4'b0111
    } seq_state_e;

    typedef struct packed {
        logic [CMD_W-1:0] in_freq_khz;
        logic [CMD_W-1:0] target_khz;
        logic [CMD_W-1:0] mode;
        logic [CMD_W-1:0] lock_poll_limit;
    } request_s;

    typedef struct packed {
        result_code_e code;
        logic [CMD_W-1:0] sys_freq_khz;
    } result_s;

    typedef struct packed {
        logic [1:0] post_code;
        logic [4:0] feedback_m1;
    } pll_control_s;

endpackage : pll_setup_pkg

// File: lock_sync.sv
module lock_sync import pll_setup_pkg::*; (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic async_in,
    output logic sync_out
);

    logic stage1;

    // First stage is read only by the second stage.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            stage1 <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule : lock_sync

// File: freq_divider.sv
module freq_divider import pll_setup_pkg::*; (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [FREQ_W-1:0] dividend,
    input wire logic [FREQ_W-1:0] divisor,
    output logic [FREQ_W-1:0] quotient,
    output logic [FREQ_W-1:0] remainder,
    output logic done
);

    logic [4:0] steps;
    logic [FREQ_W:0] shifted;

    assign shifted = {remainder, quotient[FREQ_W-1]};

    // Restoring division, one quotient bit per cycle.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            quotient <= '0;
            remainder <= '0;
            steps <= '0;
            done <= 1'b0;
        end else if (start) begin
            quotient <= dividend;
            remainder <= '0;
            steps <= DIV_STEPS;
            done <= 1'b0;
        end else if (steps != 5'h00) begin
            if (shifted >= {1'b0, divisor}) begin
                remainder <= FREQ_W'(shifted - {1'b0, divisor});
                quotient <= {quotient[FREQ_W-2:0], 1'b1};
            end else begin
                remainder <= shifted[FREQ_W-1:0];
                quotient <= {quotient[FREQ_W-2:0], 1'b0};
            end
            steps <= steps - 5'h01;
            done <= (steps == 5'h01);
        end else begin
            done <= 1'b0;
        end
    end

endmodule : freq_divider

// File: pll_lock_model.sv
module pll_lock_model import pll_setup_pkg::*; (
    input wire logic core_clk,
    input wire logic rst,
    input wire pll_control_s pll_control_setting,
    input wire logic slow,
    input wire logic stuck,
    output logic pll_lock_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    pll_control_s last;
    logic [7:0] cnt;
    // A new setting drops lock, which returns after a short or a long settle time.
    always_ff @(posedge core_clk) begin
        last <= pll_control_setting;
        if (rst || last != pll_control_setting) begin
            cnt <= 8'h00;
        end else if (cnt != 8'hff) begin
            cnt <= cnt + 8'h01;
        end
    end
    assign pll_lock_pin = !stuck && !rst && last == pll_control_setting
        && cnt >= (slow ? 8'hc8 : 8'h05);
endmodule : pll_lock_model

// File: pll_setup_sequencer_tb_top.sv
module pll_setup_sequencer_tb_top import pll_setup_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [31:0] fi, tg, md, lim;
        logic [2:0] code;
        logic [31:0] f;
        logic [1:0] src;
    } row_s;
    logic core_clk = 0, rst = 1, req_valid = 0, slow = 0, stuck = 0;
    request_s req = '0;
    logic pll_lock_pin, busy, result_valid, main_clock_from_pll, pll_bypass;
    result_s result;
    pll_control_s pll_control_setting;
    logic [7:0] system_clock_divider;
    logic [16:0] snap;
    int fails = 0, checked = 0, n;
    row_s rows [12] = '{
        '{32'h2ee0, 32'h1770, 32'h0, 32'h0, 3'h0, 32'h1770, 2'b01},
        '{32'h2ee0, 32'hea60, 32'h0, 32'h0, 3'h1, 32'h2ee0, 2'b00},
        '{32'h2ee0, 32'h0, 32'h1, 32'h0, 3'h1, 32'h2ee0, 2'b00},
        '{32'h270f, 32'h2ee0, 32'h0, 32'h0, 3'h1, 32'h270f, 2'b00},
        '{32'h61a9, 32'h2ee0, 32'h0, 32'h0, 3'h1, 32'h61a9, 2'b00},
        '{32'h2ee0, 32'h28, 32'h1, 32'h0, 3'h1, 32'h2ee0, 2'b00},
        '{32'h2ee0, 32'h2ee0, 32'h4, 32'h0, 3'h2, 32'h2ee0, 2'b00},
        '{32'h2ee0, 32'h61a8, 32'h0, 32'h0, 3'h3, 32'h2ee0, 2'b00},
        '{32'h2ee0, 32'h61a8, 32'h1, 32'h960, 3'h0, 32'h5dc0, 2'b10},
        '{32'h2ee0, 32'h61a8, 32'h2, 32'he10, 3'h0, 32'h8ca0, 2'b10},
        '{32'h2ee0, 32'h4074, 32'h3, 32'h0, 3'h0, 32'h3e80, 2'b10},
        '{32'h2710, 32'hc350, 32'h0, 32'h1388, 3'h0, 32'hc350, 2'b10}
    };

    pll_setup_sequencer dut (.core_clk(core_clk), .rst(rst), .req_valid(req_valid), .req(req),
        .pll_lock_pin(pll_lock_pin), .busy(busy), .result_valid(result_valid), .result(result),
        .pll_control_setting(pll_control_setting), .system_clock_divider(system_clock_divider),
        .main_clock_from_pll(main_clock_from_pll), .pll_bypass(pll_bypass));
    pll_lock_model partner (.core_clk(core_clk), .rst(rst), .slow(slow), .stuck(stuck),
        .pll_control_setting(pll_control_setting), .pll_lock_pin(pll_lock_pin));

    task end_sim;
        if (fails == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_sim

    task chk(input logic [35:0] got, input logic [35:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task wait_res;
        n = 0;
        while (result_valid !== 1'b1 && n < 5000) begin
            @(negedge core_clk);
            n++;
        end
        if (n == 5000) fails++;
    endtask : wait_res

    task run(input logic [31:0] fi, input logic [31:0] tg, input logic [31:0] md,
             input logic [31:0] lim);
        snap = {system_clock_divider, pll_bypass, main_clock_from_pll, pll_control_setting};
        @(negedge core_clk);
        req = '{fi, tg, md, lim};
        req_valid = 1;
        @(negedge core_clk);
        req_valid = 0;
        chk(busy, 1'b1);
        wait_res();
    endtask : run

    task chk_rst;
        chk({busy, result_valid, system_clock_divider, main_clock_from_pll, pll_bypass,
             pll_control_setting}, {2'b00, 8'h01, 2'b00, 7'h00});
        chk(result, 35'h0);
    endtask : chk_rst

    initial forever #5 core_clk = ~core_clk;

    initial begin
        #200us;
        fails++;
        end_sim();
    end

    initial begin
        repeat (16) @(negedge core_clk);
        chk_rst();
        rst = 0;
        foreach (rows[i]) begin
            run(rows[i].fi, rows[i].tg, rows[i].md, rows[i].lim);
            chk(result, {rows[i].code, rows[i].f});
            if (rows[i].code != 3'h0) begin
                chk({system_clock_divider, pll_bypass, main_clock_from_pll,
                     pll_control_setting}, snap);
            end else begin
                chk({main_clock_from_pll, pll_bypass}, rows[i].src);
                chk(rows[i].fi * (pll_bypass ? 32'h1 : pll_control_setting.feedback_m1 + 32'h1)
                    / system_clock_divider, rows[i].f);
            end
        end
        // A second request held up while busy must be ignored.
        @(negedge core_clk);
        req = '{32'h2ee0, 32'h1770, 32'h0, 32'h0};
        req_valid = 1;
        @(negedge core_clk);
        req.mode = 32'h5;
        repeat (3) @(negedge core_clk);
        req_valid = 0;
        wait_res();
        repeat (10) @(negedge core_clk);
        chk({busy, result}, {1'b0, 3'h0, 32'h1770});
        stuck = 1;
        run(32'h2ee0, 32'h8ca0, 32'h0, 32'h3);
        chk(result, {3'h4, 32'h2ee0});
        chk({system_clock_divider, pll_bypass, main_clock_from_pll,
             pll_control_setting}, snap);
        stuck = 0;
        run(32'h2ee0, 32'h8ca0, 32'h0, 32'h0);
        chk(result, {3'h0, 32'h8ca0});
        slow = 1;
        run(32'h2ee0, 32'h5dc0, 32'h0, 32'h0);
        chk(result, {3'h0, 32'h5dc0});
        slow = 0;
        // Reset in mid-search returns every output to its reset value.
        @(negedge core_clk);
        req = '{32'h2ee0, 32'h4074, 32'h3, 32'h0};
        req_valid = 1;
        @(negedge core_clk);
        req_valid = 0;
        repeat (5) @(negedge core_clk);
        rst = 1;
        repeat (2) @(negedge core_clk);
        chk_rst();
        rst = 0;
        repeat (2) @(negedge core_clk);
        chk_rst();
        run(32'h2ee0, 32'h1770, 32'h0, 32'h0);
        chk(result, {3'h0, 32'h1770});
        end_sim();
    end
endmodule : pll_setup_sequencer_tb_top
